// file: rtl/lcp_consts.vh
// constants of the lcd column driver host port
`ifndef LCP_CONSTS_VH
`define LCP_CONSTS_VH

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define LCP_COLS        64
`define LCP_COL_W       6
`define LCP_PAGE_W      3
`define LCP_ADDR_W      9
`define LCP_RAM_DEPTH   512
`define LCP_COL_LAST    6'h3f

// ---------------------------------------------------------------
// instruction encodings
// ---------------------------------------------------------------
`define LCP_OP_DISP     7'h1f
`define LCP_OP_COL      2'h1
`define LCP_OP_START    2'h3
`define LCP_OP_PAGE     5'h17

// ---------------------------------------------------------------
// status byte bit positions
// ---------------------------------------------------------------
`define LCP_ST_BUSY     7
`define LCP_ST_OFF      5
`define LCP_ST_RST      4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LCP_START_RST   6'h00
`define LCP_COL_RST     6'h00
`define LCP_PAGE_RST    3'h0
`define LCP_ROW_RST     6'h00
`define LCP_OFF_RST     1'b1
`define LCP_BYTE_RST    8'h00

`endif

// file: rtl/lcp_fall_det.v
// falling edge detector for synchronous pin inputs
`timescale 1ns/1ps
module lcp_fall_det (
  input  wire clk,
  input  wire rst,
  input  wire sig,
  output wire fall
);

  reg sig_r;

  // ---------------------------------------------------------------
  // previous level
  // ---------------------------------------------------------------
  // reset to low so a pin held low at release gives no false edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sig_r <= 1'b0;
    end else begin
      sig_r <= sig;
    end
  end

  assign fall = sig_r & ~sig;

endmodule // lcp_fall_det

// file: rtl/lcp_ram.v
// display ram, single port, registered read data
`timescale 1ns/1ps
`include "lcp_consts.vh"
module lcp_ram (
  input  wire                   clk,
  input  wire                   we,
  input  wire [`LCP_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  output reg  [7:0]             rdata
);

  reg [7:0] mem [0:`LCP_RAM_DEPTH-1];

  // ---------------------------------------------------------------
  // read first, read data one cycle after the address
  // ---------------------------------------------------------------
  // contents are not reset; the host clears the screen itself
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // lcp_ram

// file: rtl/lcp_host_port.v
// host port and display state of the 64 column lcd segment driver
`timescale 1ns/1ps
`include "lcp_consts.vh"
// Behaviour
// - ignore transfers unless all chip selects active
// - reset and mapping act without chip selects
// - write byte latched on strobe fall, then stored
// - select and direction decode four access kinds
// - ram read needs dummy access first
// - status read answers on first access
// - reset pin low: display off, start line zero
// - reset pin low: only status read accepted
// - status bit 7 is busy flag
// - display off forces all segments non-selected
// - reset pin low blanks every segment
// - status bit 5 shows display off flag
// - display flag change applied on line tick
// - page changes only by instruction
// - column loadable, advances after data access
// - ram bit one lights its dot
// - mapping input picks segment order
// - start line presets row counter at frame sync
// - display on/off instruction decode
// - set column instruction decode
// - set start line and set page decode
module lcp_host_port (
  input  wire        clk,
  input  wire        rst,
  input  wire        chip_sel_a_n,
  input  wire        chip_sel_b_n,
  input  wire        chip_sel_c,
  input  wire        reset_n,
  input  wire        cmd_or_data,
  input  wire        rd_not_wr,
  input  wire        strobe,
  input  wire [7:0]  db_in,
  output reg  [7:0]  db_out,
  output wire        db_oe_n,
  input  wire        map_normal,
  input  wire        line_tick,
  input  wire        frame_sync,
  output reg  [63:0] seg_data,
  output reg  [5:0]  row_addr
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_CAPT = 3'b100;

  reg  [2:0]             state_r;
  reg  [2:0]             state_nxt;
  reg  [7:0]             in_reg_r;     // input holding register
  reg  [7:0]             out_reg_r;    // output register for ram reads
  reg                    op_cmd_r;     // latched select
  reg                    op_rd_r;      // latched direction
  reg  [`LCP_COL_W-1:0]  col_r;
  reg  [`LCP_COL_W-1:0]  col_nxt;
  reg  [`LCP_PAGE_W-1:0] page_r;
  reg  [`LCP_COL_W-1:0]  start_r;
  reg                    off_req_r;    // flag as written by instruction
  reg                    off_r;        // flag applied to segments
  reg  [7:0]             db_prev_r;
  reg                    sel_prev_r;
  reg                    cmd_prev_r;
  reg                    rd_prev_r;
  reg                    scan_act_r;
  reg  [`LCP_COL_W-1:0]  scan_col_r;
  reg                    scan_pend_r;
  reg  [`LCP_COL_W-1:0]  scan_col_q_r;
  reg  [63:0]            line_buf_r;
  reg                    ram_we;
  reg  [`LCP_ADDR_W-1:0] ram_addr;
  wire [7:0]             ram_rdata;
  wire                   strobe_fall;
  wire                   tick_fall;
  wire                   chip_sel;
  wire                   busy;
  wire                   host_ram;
  wire                   accept;
  wire [7:0]             status;
  wire [63:0]            line_rev;

  // ---------------------------------------------------------------
  // edge detection and bus sampling
  // ---------------------------------------------------------------
  lcp_fall_det u_strobe_fall (
    .clk  (clk),
    .rst  (rst),
    .sig  (strobe),
    .fall (strobe_fall)
  );

  lcp_fall_det u_tick_fall (
    .clk  (clk),
    .rst  (rst),
    .sig  (line_tick),
    .fall (tick_fall)
  );

  assign chip_sel = ~chip_sel_a_n & ~chip_sel_b_n & chip_sel_c;

  // values seen while the strobe was still high; hold time is short
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      db_prev_r  <= `LCP_BYTE_RST;
      sel_prev_r <= 1'b0;
      cmd_prev_r <= 1'b0;
      rd_prev_r  <= 1'b0;
    end else begin
      db_prev_r  <= db_in;
      sel_prev_r <= chip_sel;
      cmd_prev_r <= cmd_or_data;
      rd_prev_r  <= rd_not_wr;
    end
  end

  // ---------------------------------------------------------------
  // access acceptance
  // ---------------------------------------------------------------
  // status reads never enter the state machine, so they never reject
  assign busy   = ~state_r[0];
  assign accept = strobe_fall & sel_prev_r
                  & reset_n
                  & ~busy
                  & ~(~cmd_prev_r & rd_prev_r);

  // ---------------------------------------------------------------
  // status byte and bus drive
  // ---------------------------------------------------------------
  assign status = {busy, 1'b0, off_r, ~reset_n, 4'h0};

  // drive only on a selected read while the strobe is high
  assign db_oe_n = ~(chip_sel & rd_not_wr & strobe
                     & (~cmd_or_data | reset_n));

  // status read gives live status, data read gives the older latch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      db_out <= `LCP_BYTE_RST;
    end else if (~cmd_or_data) begin
      db_out <= status;
    end else begin
      db_out <= out_reg_r;
    end
  end

  // ---------------------------------------------------------------
  // host operation sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (op_cmd_r & op_rd_r) begin
          state_nxt = ST_CAPT;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CAPT: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      in_reg_r <= `LCP_BYTE_RST;
      op_cmd_r <= 1'b0;
      op_rd_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        in_reg_r <= db_prev_r;
        op_cmd_r <= cmd_prev_r;
        op_rd_r  <= rd_prev_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // ram port arbitration
  // ---------------------------------------------------------------
  // host data access wins; the scan just waits a cycle
  assign host_ram = state_r[1] & op_cmd_r;

  always @* begin
    ram_we   = 1'b0;
    ram_addr = {row_addr[5:3], scan_col_r};
    if (host_ram) begin
      ram_addr = {page_r, col_r};
      ram_we   = ~op_rd_r;
    end
  end

  lcp_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (in_reg_r),
    .rdata (ram_rdata)
  );

  // ---------------------------------------------------------------
  // column counter, page and instruction execution
  // ---------------------------------------------------------------
  always @* begin
    col_nxt = col_r;
    if (host_ram) begin
      col_nxt = col_r + 6'h01;
    end else if (state_r[1] & ~op_cmd_r & (in_reg_r[7:6] == `LCP_OP_COL)) begin
      col_nxt = in_reg_r[5:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      col_r     <= `LCP_COL_RST;
      page_r    <= `LCP_PAGE_RST;
      start_r   <= `LCP_START_RST;
      off_req_r <= `LCP_OFF_RST;
      out_reg_r <= `LCP_BYTE_RST;
    end else begin
      col_r <= col_nxt;
      if (state_r[2]) begin
        out_reg_r <= ram_rdata;
      end
      if (~reset_n) begin
        off_req_r <= 1'b1;
        start_r   <= `LCP_START_RST;
      end else if (state_r[1] & ~op_cmd_r) begin
        if (in_reg_r[7:1] == `LCP_OP_DISP) begin
          off_req_r <= ~in_reg_r[0];
        end else if (in_reg_r[7:6] == `LCP_OP_START) begin
          start_r <= in_reg_r[5:0];
        end else if (in_reg_r[7:3] == `LCP_OP_PAGE) begin
          page_r <= in_reg_r[2:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // line scan: fetch one bit per column for the current row
  // ---------------------------------------------------------------
  // 64 ram cycles per line, far below any line tick period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_act_r   <= 1'b0;
      scan_col_r   <= `LCP_COL_RST;
      scan_pend_r  <= 1'b0;
      scan_col_q_r <= `LCP_COL_RST;
      line_buf_r   <= 64'h0000000000000000;
    end else begin
      scan_pend_r <= 1'b0;
      if (tick_fall) begin
        scan_act_r <= 1'b1;
        scan_col_r <= `LCP_COL_RST;
      end else if (scan_act_r & ~host_ram) begin
        scan_pend_r  <= 1'b1;
        scan_col_q_r <= scan_col_r;
        scan_col_r   <= scan_col_r + 6'h01;
        if (scan_col_r == `LCP_COL_LAST) begin
          scan_act_r <= 1'b0;
        end
      end
      if (scan_pend_r) begin
        line_buf_r[scan_col_q_r] <= ram_rdata[row_addr[2:0]];
      end
    end
  end

  // ---------------------------------------------------------------
  // column to segment mapping
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `LCP_COLS; gi = gi + 1) begin : g_rev
      assign line_rev[gi] = line_buf_r[`LCP_COLS-1-gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // row counter, display flag and segment latch
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      off_r    <= `LCP_OFF_RST;
      row_addr <= `LCP_ROW_RST;
      seg_data <= 64'h0000000000000000;
    end else begin
      if (~reset_n) begin
        off_r <= 1'b1;
      end else if (tick_fall) begin
        off_r <= off_req_r;
      end
      if (tick_fall) begin
        if (frame_sync) begin
          row_addr <= start_r;
        end else begin
          row_addr <= row_addr + 6'h01;
        end
      end
      // blanking is immediate under the reset pin, not tick aligned
      if (~reset_n) begin
        seg_data <= 64'h0000000000000000;
      end else if (tick_fall) begin
        if (off_req_r) begin
          seg_data <= 64'h0000000000000000;
        end else if (map_normal) begin
          seg_data <= line_buf_r;
        end else begin
          seg_data <= line_rev;
        end
      end
    end
  end

endmodule // lcp_host_port

// file: verif/lcp_host_port_monitor.sv
// checker of host port bus and display rules
`timescale 1ns/1ps
module lcp_host_port_monitor (
  input wire        clk,
  input wire        rst,
  input wire        chip_sel_a_n,
  input wire        chip_sel_b_n,
  input wire        chip_sel_c,
  input wire        reset_n,
  input wire        cmd_or_data,
  input wire        rd_not_wr,
  input wire        strobe,
  input wire [7:0]  db_in,
  input wire [7:0]  db_out,
  input wire        db_oe_n,
  input wire        map_normal,
  input wire        line_tick,
  input wire        frame_sync,
  input wire [63:0] seg_data,
  input wire [5:0]  row_addr
);
  // ---------------------------------------------------------------
  // bus output enable
  // ---------------------------------------------------------------
  wire sel = !chip_sel_a_n && !chip_sel_b_n && chip_sel_c;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_status:
    assert property (sel && rd_not_wr && strobe && !cmd_or_data |-> !db_oe_n) else $error("status not driven");
  a_oe_unsel:
    assert property (!sel |-> db_oe_n) else $error("bus driven unselected");
  a_oe_rst_read:
    assert property (!reset_n && cmd_or_data |-> db_oe_n) else $error("data read under reset pin");
  // ---------------------------------------------------------------
  // status byte and busy
  // ---------------------------------------------------------------
  a_status_fixed:
    assert property ($past(!cmd_or_data) |-> db_out[6] == 1'b0 && db_out[3:0] == 4'h0)
      else $error("status fixed bits");
  a_busy_set:
    assert property ($fell(strobe) && $past(sel) && !$past(cmd_or_data) && !$past(rd_not_wr) && reset_n
      && $past(reset_n) && !db_out[7] && !cmd_or_data |-> ##[1:3] db_out[7]) else $error("busy not set");
  a_busy_clear:
    assert property ($rose(db_out[7]) && !cmd_or_data && $past(!cmd_or_data) |-> ##[1:3] !db_out[7])
      else $error("busy stuck");
  // ---------------------------------------------------------------
  // reset pin and line clock
  // ---------------------------------------------------------------
  a_rst_blank:
    assert property ($past(!reset_n) && $past(!reset_n, 2) |-> seg_data == 64'h0) else $error("seg not blank");
  a_rst_status:
    assert property ($past(!reset_n) && $past(!reset_n, 2) && $past(!cmd_or_data) |-> db_out[5] && db_out[4])
      else $error("reset status");
  // sync detector adds latency, so four quiet samples are demanded first
  a_line_sync:
    assert property (reset_n && $past(reset_n) && $past(reset_n, 2) && $stable(line_tick)
      && $past(line_tick) == $past(line_tick, 2) && $past(line_tick, 2) == $past(line_tick, 3)
      && $past(line_tick, 3) == $past(line_tick, 4) |-> $stable(row_addr) && $stable(seg_data))
      else $error("line output moved without tick");
endmodule // lcp_host_port_monitor

bind lcp_host_port lcp_host_port_monitor lcp_host_port_monitor_inst (
  .clk(clk), .rst(rst), .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n),
  .chip_sel_c(chip_sel_c), .reset_n(reset_n), .cmd_or_data(cmd_or_data), .rd_not_wr(rd_not_wr),
  .strobe(strobe), .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n), .map_normal(map_normal),
  .line_tick(line_tick), .frame_sync(frame_sync), .seg_data(seg_data), .row_addr(row_addr));

// file: verif/lcp_mpu_model.sv
// host microprocessor model on the strobe bus
`timescale 1ns/1ps
module lcp_mpu_model (
  input  wire       clk,
  input  wire [7:0] db_out,
  input  wire       db_oe_n,
  output reg        chip_sel_a_n,
  output reg        chip_sel_b_n,
  output reg        chip_sel_c,
  output reg        cmd_or_data,
  output reg        rd_not_wr,
  output reg        strobe,
  output reg  [7:0] db_in
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    chip_sel_a_n = 1'b1;
    chip_sel_b_n = 1'b1;
    chip_sel_c = 1'b0;
    cmd_or_data = 1'b0;
    rd_not_wr = 1'b1;
    strobe = 1'b0;
    db_in = 8'h5a;
  end
  // ---------------------------------------------------------------
  // one access; sel low leaves the third select inactive
  // ---------------------------------------------------------------
  task acc(input sel, input cmd, input rw, input [7:0] d, output [7:0] q);
    begin
      @(negedge clk);
      chip_sel_a_n = 1'b0;
      chip_sel_b_n = 1'b0;
      chip_sel_c = sel;
      cmd_or_data = cmd;
      rd_not_wr = rw;
      db_in = rw ? ~db_in : d;
      strobe = 1'b1;
      repeat (3) @(negedge clk);
      q = db_oe_n ? ~db_out : db_out; // undriven bus reads as garbage
      strobe = 1'b0;
      repeat (2) @(negedge clk);
      chip_sel_a_n = 1'b1;
      chip_sel_b_n = 1'b1;
      chip_sel_c = 1'b0;
      db_in = ~db_in;
      repeat (6) @(negedge clk); // gap outlasts the longest busy
    end
  endtask
endmodule // lcp_mpu_model

// file: verif/lcd_column_driver_host_port_tb.sv
// testbench of the lcd column driver host port
`timescale 1ns/1ps
`include "lcp_consts.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module lcd_column_driver_host_port_tb;
  reg         clk, rst, reset_n, map_normal, line_tick, frame_sync;
  wire        chip_sel_a_n, chip_sel_b_n, chip_sel_c, cmd_or_data, rd_not_wr, strobe, db_oe_n;
  wire [7:0]  db_in, db_out;
  wire [63:0] seg_data;
  wire [5:0]  row_addr;
  integer     num_errors, compares, i;
  reg  [7:0]  q;
  reg  [16:0] rows [0:3]; // page, column, byte
  // ---------------------------------------------------------------
  // design, host model, clock
  // ---------------------------------------------------------------
  lcp_host_port lcp_host_port_inst (.clk(clk), .rst(rst), .chip_sel_a_n(chip_sel_a_n),
    .chip_sel_b_n(chip_sel_b_n), .chip_sel_c(chip_sel_c), .reset_n(reset_n), .cmd_or_data(cmd_or_data),
    .rd_not_wr(rd_not_wr), .strobe(strobe), .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n),
    .map_normal(map_normal), .line_tick(line_tick), .frame_sync(frame_sync), .seg_data(seg_data),
    .row_addr(row_addr));
  lcp_mpu_model lcp_mpu_model_inst (.clk(clk), .db_out(db_out), .db_oe_n(db_oe_n),
    .chip_sel_a_n(chip_sel_a_n), .chip_sel_b_n(chip_sel_b_n), .chip_sel_c(chip_sel_c),
    .cmd_or_data(cmd_or_data), .rd_not_wr(rd_not_wr), .strobe(strobe), .db_in(db_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // access helpers
  // ---------------------------------------------------------------
  task ins(input [7:0] b); lcp_mpu_model_inst.acc(1'b1, 1'b0, 1'b0, b, q); endtask
  task stat; lcp_mpu_model_inst.acc(1'b1, 1'b0, 1'b1, 8'h00, q); endtask
  task wr(input [7:0] b); lcp_mpu_model_inst.acc(1'b1, 1'b1, 1'b0, b, q); endtask
  // dummy read, then the real one
  task rd2;
    begin
      lcp_mpu_model_inst.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
      lcp_mpu_model_inst.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
    end
  endtask
  task at(input [2:0] p, input [5:0] c);
    begin
      ins({`LCP_OP_PAGE, p});
      ins({`LCP_OP_COL, c});
    end
  endtask
  // line tick long enough for the 64 column refill
  task tick(input fr);
    begin
      @(negedge clk);
      frame_sync = fr;
      line_tick = 1'b1;
      repeat (4) @(negedge clk);
      line_tick = 1'b0;
      repeat (150) @(negedge clk);
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reset_n = 1'b1;
    map_normal = 1'b1;
    line_tick = 1'b0;
    frame_sync = 1'b0;
    num_errors = 0;
    compares = 0;
    rows[0] = {3'h0, 6'h00, 8'h01};
    rows[1] = {3'h0, 6'h05, 8'ha5};
    rows[2] = {3'h0, 6'h09, 8'h02};
    rows[3] = {3'h7, 6'h3f, 8'h3c};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    stat;
    `CHK(q, 8'h20)
    for (i = 0; i < 4; i = i + 1) begin
      at(rows[i][16:14], rows[i][13:8]);
      wr(rows[i][7:0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      at(rows[i][16:14], rows[i][13:8]);
      rd2;
      `CHK(q, rows[i][7:0])
    end
    at(3'h1, 6'h3f);
    wr(8'h5a);
    wr(8'hc3);
    at(3'h1, 6'h00);
    rd2;
    `CHK(q, 8'hc3)
    at(3'h1, 6'h3f);
    rd2;
    `CHK(q, 8'h5a)
    // a third read returns the byte fetched by the second, which wrapped to column 0
    lcp_mpu_model_inst.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
    `CHK(q, 8'hc3)
    lcp_mpu_model_inst.acc(1'b0, 1'b0, 1'b0, {`LCP_OP_DISP, 1'b1}, q);
    tick(1'b0);
    stat;
    `CHK(q, 8'h20)
    ins({`LCP_OP_DISP, 1'b1});
    ins({`LCP_OP_START, 6'h00});
    stat;
    `CHK(q, 8'h20)
    tick(1'b1);
    stat;
    `CHK(q, 8'h00)
    `CHK(row_addr, 6'h00)
    tick(1'b0);
    `CHK(({seg_data[9], seg_data[5], seg_data[0]}), 3'b011)
    `CHK(row_addr, 6'h01)
    map_normal = 1'b0;
    tick(1'b1);
    tick(1'b1);
    `CHK(({seg_data[54], seg_data[58], seg_data[63]}), 3'b011)
    map_normal = 1'b1;
    ins({`LCP_OP_DISP, 1'b0});
    tick(1'b1);
    `CHK(seg_data, 64'h0)
    // back on so the reset pin below has a lit line to blank
    ins({`LCP_OP_DISP, 1'b1});
    ins({`LCP_OP_START, 6'h05});
    tick(1'b1);
    `CHK(row_addr, 6'h05)
    `CHK(({seg_data[9], seg_data[5], seg_data[0]}), 3'b011)
    at(3'h0, 6'h09);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    stat;
    `CHK(q, 8'h30)
    `CHK(seg_data, 64'h0)
    ins({`LCP_OP_COL, 6'h05});
    wr(8'hee);
    // data read under the reset pin must neither drive the bus nor move the column
    lcp_mpu_model_inst.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
    reset_n = 1'b1;
    i = 0;
    stat;
    while ((q[7] | q[4]) !== 1'b0 && i < 20) begin
      stat;
      i = i + 1;
    end
    `CHK(q, 8'h20)
    tick(1'b1);
    `CHK(row_addr, 6'h00)
    `CHK(seg_data, 64'h0)
    wr(8'h77);
    at(3'h0, 6'h09);
    rd2;
    `CHK(q, 8'h77)
    at(3'h0, 6'h05);
    rd2;
    `CHK(q, 8'ha5)
    final_report;
  end
  // watchdog: tests need about 2100 cycles, allow 20000
  initial begin
    #400000;
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // lcd_column_driver_host_port_tb
